// File: cef_error_status.sv
// error flags, link state machine and register slave of the contactless front end
`timescale 1ns/1ps
module cef_error_status #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                nrst,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [ADDR_W-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// device events
	input  wire cef_pkg::cef_cmd_type  cmd,
	input  wire cef_pkg::cef_fifo_type fifo,
	input  wire cef_pkg::cef_rx_type   rx,
	input  wire cef_pkg::cef_nvm_type  nvm,
	// controls toward the datapath
	output logic                     fifoWriteAccept,
	output logic                     rxByteStore,
	output logic                     rxStop,
	output logic                     receive_interrupt_request,
	output logic                     decoderEnable,
	// status and interrupts
	output logic      [2:0]          linkState,
	output logic                     errIrqReq,
	output logic                     irq
);
	// the register index is taken from paddr[9:2], so narrower buses cannot reach the map
	if (ADDR_W < 10) begin : g_addr_check
		$error("ADDR_W must be at least 10");
	end

	//==============================================================
	// state code mapping
	function automatic logic [2:0] stateCode(input cef_pkg::cef_state_type s);
		logic [2:0] c;
		c = cef_pkg::CODE_IDLE;
		unique case (s)
			cef_pkg::ST_IDLE:     c = cef_pkg::CODE_IDLE;
			cef_pkg::ST_TXWAIT:   c = cef_pkg::CODE_TXWAIT;
			cef_pkg::ST_TX:       c = cef_pkg::CODE_TX;
			cef_pkg::ST_RXWAIT:   c = cef_pkg::CODE_RXWAIT;
			cef_pkg::ST_WAITDATA: c = cef_pkg::CODE_WAITDATA;
			cef_pkg::ST_RECV:     c = cef_pkg::CODE_RECV;
			default:              c = cef_pkg::CODE_IDLE;
		endcase
		return c;
	endfunction : stateCode

	//==============================================================
	// state
	cef_pkg::cef_state_type state;
	cef_pkg::cef_state_type next_state;
	logic [7:0] errFlags;
	logic [7:0] irqStatus;
	logic [7:0] irqMask;
	logic [2:0] control;
	logic       transceive;
	logic       collValid;
	logic [6:0] collPos;

	//==============================================================
	// event decode
	wire inRecv    = (state == cef_pkg::ST_RECV);
	wire rxPhase   = inRecv | (state == cef_pkg::ST_RXWAIT) | (state == cef_pkg::ST_WAITDATA);
	wire frameDone = inRecv & rx.frameEnd;
	wire tooFewBits = rx.bitCount < cef_pkg::MIN_FRAME_BITS;
	wire tooFewBytes = rx.bitCount < cef_pkg::MIN_SUPPRESS_BITS;
	wire shortFrame = frameDone & tooFewBits;
	// noise bursts are dropped without a receive interrupt so the reader keeps listening
	wire discard = shortFrame | (frameDone & control[cef_pkg::CTRL_SUPPRESS] & tooFewBytes);
	wire collHit = rx.collision & ~rx.collisionInEof;
	wire protHit = inRecv & (rx.stopBitErr | rx.sofErr | rx.byteCountErr);
	wire integHit = rx.parityErr | rx.crcErr | (collHit & control[cef_pkg::CTRL_COLL_INTEG]);
	wire wrViolation = fifo.write & (fifo.crcSending | rxPhase | cmd.auth);
	wire clStart = cmd.start & (state == cef_pkg::ST_IDLE);
	wire enterWaitTrx = (state == cef_pkg::ST_RXWAIT) & cmd.rxWaitDone & transceive;
	wire rxClear = (clStart & (cmd.kind == cef_pkg::CMD_RECEIVE)) | enterWaitTrx;
	wire wrvClear = control[cef_pkg::CTRL_MULTI] ? cmd.errFlagsStored : clStart;

	wire [7:0] setVec = {nvm.done & nvm.fail,
	                     wrViolation,
	                     fifo.write & fifo.full,
	                     shortFrame,
	                     fifo.txRequest & fifo.empty,
	                     collHit,
	                     protHit,
	                     integHit};
	wire [7:0] clrVec = {nvm.start, wrvClear, fifo.flush, rxClear, clStart, rxClear, rxClear, rxClear};
	// a flag raised in the cycle it is cleared survives
	wire [7:0] next_errFlags = (errFlags & ~clrVec) | setVec;

	//==============================================================
	// link state machine
	always_comb begin
		next_state = state;
		if (cmd.stop) begin
			next_state = cef_pkg::ST_IDLE;
		end else begin
			unique case (state)
				cef_pkg::ST_IDLE: begin
					if (clStart) begin
						next_state = (cmd.kind == cef_pkg::CMD_RECEIVE) ? cef_pkg::ST_RXWAIT : cef_pkg::ST_TXWAIT;
					end
				end
				cef_pkg::ST_TXWAIT: begin
					if (cmd.txGo) begin
						next_state = cef_pkg::ST_TX;
					end
				end
				cef_pkg::ST_TX: begin
					if (cmd.txDone) begin
						next_state = transceive ? cef_pkg::ST_RXWAIT : cef_pkg::ST_IDLE;
					end
				end
				cef_pkg::ST_RXWAIT: begin
					if (cmd.rxWaitDone) begin
						next_state = cef_pkg::ST_WAITDATA;
					end
				end
				cef_pkg::ST_WAITDATA: begin
					if (rx.sofDetected) begin
						next_state = cef_pkg::ST_RECV;
					end
				end
				cef_pkg::ST_RECV: begin
					if (protHit) begin
						next_state = cef_pkg::ST_IDLE;
					end else if (frameDone) begin
						next_state = discard ? cef_pkg::ST_WAITDATA : cef_pkg::ST_IDLE;
					end
				end
				default: next_state = cef_pkg::ST_IDLE;
			endcase
		end
	end

	//==============================================================
	// apb decode
	wire [7:0] idx     = paddr[9:2];
	wire       setup   = psel & ~penable;
	wire       wrEn    = psel & penable & pready & pwrite;
	wire       mapped  = (idx == cef_pkg::IDX_ERROR) | (idx == cef_pkg::IDX_STATE) |
	                     (idx == cef_pkg::IDX_IRQ_STATUS) | (idx == cef_pkg::IDX_IRQ_MASK) |
	                     (idx == cef_pkg::IDX_CONTROL) | (idx == cef_pkg::IDX_COLL_POS);
	wire       wrMask  = wrEn & (idx == cef_pkg::IDX_IRQ_MASK);
	wire       wrCtrl  = wrEn & (idx == cef_pkg::IDX_CONTROL);
	wire [7:0] w1c     = (wrEn & (idx == cef_pkg::IDX_IRQ_STATUS)) ? pwdata[7:0] : 8'h00;
	// error and state words have no write path at all
	wire [7:0] readByte = (idx == cef_pkg::IDX_ERROR)      ? errFlags :
	                      (idx == cef_pkg::IDX_STATE)      ? {5'h00, linkState} :
	                      (idx == cef_pkg::IDX_IRQ_STATUS) ? irqStatus :
	                      (idx == cef_pkg::IDX_IRQ_MASK)   ? irqMask :
	                      (idx == cef_pkg::IDX_CONTROL)    ? {5'h00, control} :
	                      (idx == cef_pkg::IDX_COLL_POS)   ? {collValid, collPos} : 8'h00;
	wire [7:0] next_irqStatus = (irqStatus & ~w1c) | (setVec & ~errFlags);
	wire [7:0] next_irqMask   = wrMask ? pwdata[7:0] : irqMask;

	//==============================================================
	// registers
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			irqMask <= cef_pkg::MASK_RST;
			control <= cef_pkg::CTRL_RST;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= setup ? {24'h00_0000, readByte} : 32'h0000_0000;
			irqMask <= next_irqMask;
			if (wrCtrl) begin
				control <= pwdata[2:0];
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			state      <= cef_pkg::ST_IDLE;
			errFlags   <= cef_pkg::ERR_RST;
			irqStatus  <= cef_pkg::ERR_RST;
			transceive <= 1'b0;
			linkState  <= cef_pkg::CODE_IDLE;
		end else begin
			state      <= next_state;
			errFlags   <= next_errFlags;
			irqStatus  <= next_irqStatus;
			linkState  <= stateCode(next_state);
			if (clStart) begin
				transceive <= (cmd.kind == cef_pkg::CMD_TRANSCEIVE);
			end
		end
	end

	// only the first collision of a frame is kept
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			collValid <= 1'b0;
			collPos   <= 7'h00;
		end else if (collHit & (~collValid | rxClear)) begin
			collValid <= 1'b1;
			collPos   <= rx.collPos;
		end else if (rxClear) begin
			collValid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			fifoWriteAccept <= 1'b0;
			rxByteStore     <= 1'b0;
			rxStop          <= 1'b0;
			receive_interrupt_request           <= 1'b0;
			decoderEnable   <= 1'b0;
			errIrqReq       <= 1'b0;
			irq             <= 1'b0;
		end else begin
			fifoWriteAccept <= fifo.write & ~fifo.full & ~errFlags[cef_pkg::BIT_OVF];
			rxByteStore     <= inRecv & rx.byteValid & ~protHit;
			rxStop          <= protHit;
			receive_interrupt_request           <= frameDone & ~discard & ~protHit;
			decoderEnable   <= (next_state == cef_pkg::ST_WAITDATA) | (next_state == cef_pkg::ST_RECV);
			errIrqReq       <= |(next_errFlags & cef_pkg::ERR_IRQ_SEL);
			irq             <= |(next_irqStatus & next_irqMask);
		end
	end

	//==============================================================
	// assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_nvm_fail: assert property (nvm.done & nvm.fail |=> errFlags[cef_pkg::BIT_NVM])
		else $error("nvm failure not flagged");
	a_wrv_set: assert property (wrViolation |=> errFlags[cef_pkg::BIT_WRV])
		else $error("write violation not flagged");
	a_wrv_clear: assert property (wrvClear & ~wrViolation |=> ~errFlags[cef_pkg::BIT_WRV])
		else $error("write violation not cleared");
	a_ovf_drop: assert property (errFlags[cef_pkg::BIT_OVF] & fifo.write |=> ~fifoWriteAccept)
		else $error("write accepted while overflow set");
	a_short_flag: assert property (shortFrame |=> errFlags[cef_pkg::BIT_SHORT])
		else $error("short frame not flagged");
	a_short_quiet: assert property (discard & ~cmd.stop & ~protHit |=> ~receive_interrupt_request & decoderEnable)
		else $error("short frame not discarded silently");
	a_rx_clear: assert property (rxClear & ~collHit & ~integHit |=> (errFlags & 8'h17) == 8'h00)
		else $error("receive flags not cleared");
	a_empty_tx: assert property (fifo.txRequest & fifo.empty |=> errFlags[cef_pkg::BIT_EMPTY])
		else $error("empty transmit not flagged");
	a_eof_coll: assert property (rx.collision & rx.collisionInEof & ~errFlags[cef_pkg::BIT_COLL] |=>
		~errFlags[cef_pkg::BIT_COLL])
		else $error("end-of-frame collision flagged");
	a_prot_stop: assert property (protHit & ~cmd.stop |=> rxStop & ~rxByteStore &
		(linkState == cef_pkg::CODE_IDLE))
		else $error("protocol error did not stop reception");
	a_integ_go: assert property (inRecv & integHit & ~protHit & ~rx.frameEnd & ~cmd.stop |=>
		errFlags[cef_pkg::BIT_INTEG] & (linkState == cef_pkg::CODE_RECV))
		else $error("integrity error stopped reception");
	a_coll_integ: assert property (collHit & control[cef_pkg::CTRL_COLL_INTEG] |=> errFlags[cef_pkg::BIT_INTEG])
		else $error("collision not counted as integrity error");
	a_code_legal: assert property (linkState != 3'h4)
		else $error("unused link state code");
	a_err_irq: assert property (errIrqReq == |(errFlags & cef_pkg::ERR_IRQ_SEL))
		else $error("error interrupt request mismatch");

	c_short_frame: cover property (shortFrame ##1 decoderEnable);
	c_prot_error:  cover property (protHit ##1 rxStop);
	c_overflow:    cover property (fifo.write & fifo.full ##1 fifo.write ##1 ~fifoWriteAccept);
	c_irq:         cover property (irq ##[1:20] ~irq);
endmodule : cef_error_status

// File: cef_pkg.sv
// constants, types and carriers of the contactless error and status flag block
//==============================================================
// How it works
// - Flag nonvolatile command error in bit 7 when the last such command failed.
// - Flag bit 6 on FIFO writes during CRC, receive phases or authentication.
// - Clear bit 6 at command start; when multi-frame, only after error flags stored.
// - Write into full FIFO sets bit 5; later writes dropped while set.
// - Flag bit 4 when a frame after valid start has under 4 bits.
// - Drop short frames silently, decoder stays on; also under 3 bytes if suppressing.
// - Clear bits 4,2,1,0 at receive start, or entering wait-for-data in transceive.
// - Flag bit 3 when transmit is requested with an empty FIFO.
// - Flag collision in bit 2 and keep the first collision position.
// - A collision inside the end-of-frame symbol does not set the flag.
// - Flag bit 1 on bad stop bit, start or byte count; stop reception.
// - On protocol error the last byte is not stored.
// - Flag bit 0 on parity or CRC mismatch; reception goes on.
// - With collision-as-integrity set, a collision also sets bit 0.
// - Report link state as 000,001,011,101,110,111; 100 never appears.
// - Error interrupt request high while bits 6,5,3,1 or 0 set.
package cef_pkg;
	//==============================================================
	// register map: word index, byte address is four times it
	localparam logic [7:0] IDX_ERROR      = 8'h0A;
	localparam logic [7:0] IDX_STATE      = 8'h0B;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK   = 8'h21;
	localparam logic [7:0] IDX_CONTROL    = 8'h22;
	localparam logic [7:0] IDX_COLL_POS   = 8'h23;
	//==============================================================
	// error register fields
	localparam int BIT_NVM   = 7;
	localparam int BIT_WRV   = 6;
	localparam int BIT_OVF   = 5;
	localparam int BIT_SHORT = 4;
	localparam int BIT_EMPTY = 3;
	localparam int BIT_COLL  = 2;
	localparam int BIT_PROT  = 1;
	localparam int BIT_INTEG = 0;
	localparam logic [7:0] ERR_IRQ_SEL  = 8'h6B;
	localparam logic [7:0] ERR_RST      = 8'h00;
	localparam logic [7:0] MASK_RST     = 8'h00;
	localparam logic [2:0] CTRL_RST     = 3'h0;
	// control register fields
	localparam int CTRL_COLL_INTEG = 0;
	localparam int CTRL_MULTI      = 1;
	localparam int CTRL_SUPPRESS   = 2;
	//==============================================================
	// link state codes
	localparam logic [2:0] CODE_IDLE     = 3'h0;
	localparam logic [2:0] CODE_TXWAIT   = 3'h1;
	localparam logic [2:0] CODE_TX       = 3'h3;
	localparam logic [2:0] CODE_RXWAIT   = 3'h5;
	localparam logic [2:0] CODE_WAITDATA = 3'h6;
	localparam logic [2:0] CODE_RECV     = 3'h7;
	//==============================================================
	// frame limits
	localparam int RX_BITS_W = 13;
	localparam logic [RX_BITS_W-1:0] MIN_FRAME_BITS    = 13'h0004;
	localparam logic [RX_BITS_W-1:0] MIN_SUPPRESS_BITS = 13'h0018;
	//==============================================================
	// types
	typedef enum logic [1:0] {CMD_TRANSMIT, CMD_RECEIVE, CMD_TRANSCEIVE} cef_cmd_kind_type;
	typedef enum logic [2:0] {ST_IDLE, ST_TXWAIT, ST_TX, ST_RXWAIT, ST_WAITDATA, ST_RECV} cef_state_type;
	typedef struct packed {
		logic             start;
		cef_cmd_kind_type kind;
		logic             stop;
		logic             txGo;
		logic             txDone;
		logic             rxWaitDone;
		logic             errFlagsStored;
		logic             auth;
	} cef_cmd_type;
	typedef struct packed {
		logic write;
		logic full;
		logic empty;
		logic flush;
		logic crcSending;
		logic txRequest;
	} cef_fifo_type;
	typedef struct packed {
		logic                 sofDetected;
		logic                 frameEnd;
		logic [RX_BITS_W-1:0] bitCount;
		logic                 byteValid;
		logic                 collision;
		logic                 collisionInEof;
		logic [6:0]           collPos;
		logic                 stopBitErr;
		logic                 sofErr;
		logic                 byteCountErr;
		logic                 parityErr;
		logic                 crcErr;
	} cef_rx_type;
	typedef struct packed {
		logic start;
		logic done;
		logic fail;
	} cef_nvm_type;
endpackage : cef_pkg

// File: cef_rx_model.sv
// receiver front-end model that feeds frame events into the flag block
`timescale 1ns/1ps
module cef_rx_model (
	// clock
	input  wire logic           sys_clk,
	// receiver events toward the block
	output cef_pkg::cef_rx_type rx
);
	initial rx = '0;
	//==============================================================
	// one-cycle event; the count is scrambled after so a stale value never matches
	task automatic send(input cef_pkg::cef_rx_type r);
		@(posedge sys_clk);
		rx <= r;
		@(posedge sys_clk);
		rx <= '{bitCount: ~r.bitCount, default: 1'b0};
		@(negedge sys_clk);
	endtask : send
endmodule : cef_rx_model

// File: tb_top.sv
// self-checking testbench of the contactless error and status flag block
`timescale 1ns/1ps
module tb_top;
	logic                  sys_clk, nrst, psel, penable, pwrite, pready, pslverr, rdErr;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, rdata;
	logic                  fifoWriteAccept, rxByteStore, rxStop, receive_interrupt_request, decoderEnable, errIrqReq, irq;
	logic [2:0]            linkState;
	cef_pkg::cef_cmd_type  cmd;
	cef_pkg::cef_fifo_type fifo;
	cef_pkg::cef_rx_type   rx;
	cef_pkg::cef_nvm_type  nvm;
	int                    n_mismatch, total_checks, cycles;
	localparam logic [7:0] AE = cef_pkg::IDX_ERROR;
	localparam logic [7:0] AS = cef_pkg::IDX_STATE;

	cef_error_status DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd(cmd),
		.fifo(fifo), .rx(rx), .nvm(nvm), .fifoWriteAccept(fifoWriteAccept), .rxByteStore(rxByteStore),
		.rxStop(rxStop), .receive_interrupt_request(receive_interrupt_request), .decoderEnable(decoderEnable), .linkState(linkState),
		.errIrqReq(errIrqReq), .irq(irq));
	cef_rx_model PARTNER (.sys_clk(sys_clk), .rx(rx));

	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// a hang is cut short well beyond the fewer than two hundred cycles the tests need
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			complete_run();
		end
	end
	//==============================================================
	// shared drivers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge sys_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// only the bench watchdog ends a wait for pready
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rdErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic err);
		apb(1'b0, idx, 32'h0);
		chk(rdata, exp);
		chk({31'h0, rdErr}, {31'h0, err});
	endtask : rd
	task automatic scmd(input cef_pkg::cef_cmd_type c);
		@(posedge sys_clk);
		cmd <= c;
		@(posedge sys_clk);
		cmd <= '{kind: c.kind, auth: c.auth, default: 1'b0};
		@(negedge sys_clk);
	endtask : scmd
	task automatic sfifo(input cef_pkg::cef_fifo_type f);
		@(posedge sys_clk);
		fifo <= f;
		@(posedge sys_clk);
		fifo <= cef_pkg::cef_fifo_type'(f & 6'h1A);
		@(negedge sys_clk);
	endtask : sfifo
	//==============================================================
	// scenarios
	task automatic t_reset();
		rd(AE, 32'h0, 1'b0);
		rd(AS, 32'h0, 1'b0);
		rd(cef_pkg::IDX_IRQ_MASK, 32'h0, 1'b0);
		rd(8'h3F, 32'h0, 1'b1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_recv();
		scmd('{start: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		chk(linkState, cef_pkg::CODE_RXWAIT);
		sfifo('{write: 1'b1, default: 1'b0});
		scmd('{rxWaitDone: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		chk(linkState, cef_pkg::CODE_WAITDATA);
		PARTNER.send('{sofDetected: 1'b1, default: 1'b0});
		chk(linkState, cef_pkg::CODE_RECV);
		PARTNER.send('{frameEnd: 1'b1, bitCount: 13'h0003, default: 1'b0});
		chk({receive_interrupt_request, linkState}, {1'b0, cef_pkg::CODE_WAITDATA});
		PARTNER.send('{sofDetected: 1'b1, default: 1'b0});
		PARTNER.send('{stopBitErr: 1'b1, byteValid: 1'b1, default: 1'b0});
		chk({rxStop, rxByteStore, errIrqReq}, 3'h5);
		chk(linkState, cef_pkg::CODE_IDLE);
		rd(AE, 32'h52, 1'b0);
		scmd('{start: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		rd(AE, 32'h0, 1'b0);
		$display("test receive done");
	endtask : t_recv
	task automatic t_coll();
		scmd('{rxWaitDone: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		PARTNER.send('{sofDetected: 1'b1, default: 1'b0});
		PARTNER.send('{collision: 1'b1, collisionInEof: 1'b1, default: 1'b0});
		rd(AE, 32'h0, 1'b0);
		apb(1'b1, cef_pkg::IDX_CONTROL, 32'h1);
		PARTNER.send('{collision: 1'b1, collPos: 7'h12, default: 1'b0});
		PARTNER.send('{frameEnd: 1'b1, bitCount: 13'h0004, default: 1'b0});
		chk({receive_interrupt_request, linkState}, {1'b1, cef_pkg::CODE_IDLE});
		rd(AE, 32'h05, 1'b0);
		rd(cef_pkg::IDX_COLL_POS, 32'h92, 1'b0);
		$display("test collision done");
	endtask : t_coll
	task automatic t_tx();
		apb(1'b1, cef_pkg::IDX_IRQ_MASK, 32'h08);
		// a receive start wipes the collision flags left by the previous test
		scmd('{start: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		scmd('{stop: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		chk(errIrqReq, 1'b0);
		scmd('{start: 1'b1, kind: cef_pkg::CMD_TRANSMIT, default: 1'b0});
		chk(linkState, cef_pkg::CODE_TXWAIT);
		sfifo('{txRequest: 1'b1, empty: 1'b1, default: 1'b0});
		chk(errIrqReq, 1'b1);
		rd(AE, 32'h08, 1'b0);
		chk(irq, 1'b1);
		apb(1'b1, cef_pkg::IDX_IRQ_STATUS, 32'h08);
		// earlier rises of bits 6,4,2,1,0 stay latched; only bit 3 was written
		rd(cef_pkg::IDX_IRQ_STATUS, 32'h57, 1'b0);
		chk(irq, 1'b0);
		scmd('{stop: 1'b1, kind: cef_pkg::CMD_TRANSMIT, default: 1'b0});
		$display("test transmit done");
	endtask : t_tx
	task automatic t_ovf();
		sfifo('{write: 1'b1, full: 1'b1, default: 1'b0});
		chk(fifoWriteAccept, 1'b0);
		sfifo('{write: 1'b1, default: 1'b0});
		chk(fifoWriteAccept, 1'b0);
		rd(AE, 32'h28, 1'b0);
		sfifo('{flush: 1'b1, default: 1'b0});
		sfifo('{write: 1'b1, default: 1'b0});
		chk(fifoWriteAccept, 1'b1);
		@(posedge sys_clk);
		nvm <= '{done: 1'b1, fail: 1'b1, default: 1'b0};
		@(posedge sys_clk);
		nvm <= '0;
		rd(AE, 32'h88, 1'b0);
		apb(1'b1, AE, 32'hFF);
		apb(1'b1, AS, 32'hFF);
		rd(AE, 32'h88, 1'b0);
		rd(AS, 32'h0, 1'b0);
		$display("test overflow done");
	endtask : t_ovf
	task automatic t_trx();
		apb(1'b1, cef_pkg::IDX_CONTROL, 32'h6);
		scmd('{start: 1'b1, kind: cef_pkg::CMD_TRANSCEIVE, default: 1'b0});
		scmd('{txGo: 1'b1, kind: cef_pkg::CMD_TRANSCEIVE, default: 1'b0});
		chk(linkState, cef_pkg::CODE_TX);
		sfifo('{write: 1'b1, crcSending: 1'b1, default: 1'b0});
		scmd('{txDone: 1'b1, kind: cef_pkg::CMD_TRANSCEIVE, default: 1'b0});
		PARTNER.send('{parityErr: 1'b1, default: 1'b0});
		scmd('{rxWaitDone: 1'b1, kind: cef_pkg::CMD_TRANSCEIVE, default: 1'b0});
		rd(AE, 32'hC0, 1'b0);
		PARTNER.send('{sofDetected: 1'b1, default: 1'b0});
		PARTNER.send('{byteValid: 1'b1, parityErr: 1'b1, default: 1'b0});
		chk({rxByteStore, linkState}, {1'b1, cef_pkg::CODE_RECV});
		PARTNER.send('{frameEnd: 1'b1, bitCount: 13'h0010, default: 1'b0});
		chk({receive_interrupt_request, decoderEnable, linkState}, {2'h1, cef_pkg::CODE_WAITDATA});
		scmd('{stop: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		scmd('{start: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		rd(AE, 32'hC0, 1'b0);
		scmd('{errFlagsStored: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		rd(AE, 32'h80, 1'b0);
		scmd('{stop: 1'b1, kind: cef_pkg::CMD_RECEIVE, default: 1'b0});
		$display("test transceive done");
	endtask : t_trx
	//==============================================================
	// closing
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		cmd = '0;
		fifo = '0;
		nvm = '0;
		n_mismatch = 0;
		total_checks = 0;
		cycles = 0;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset();
		t_recv();
		t_coll();
		t_tx();
		t_ovf();
		t_trx();
		complete_run();
	end
endmodule : tb_top
